// File: shared/dcpw_map.svh
`ifndef DCPW_MAP_SVH
`define DCPW_MAP_SVH
// Register byte addresses on the bus
`define DCPW_TB_COUNT_ADDR   8'h00
`define DCPW_PERIOD_ADDR     8'h04
`define DCPW_TB_CTRL_ADDR    8'h08
`define DCPW_DUTY_PEND1_ADDR 8'h0c
`define DCPW_DUTY_ACT1_ADDR  8'h10
`define DCPW_CH_CTRL1_ADDR   8'h14
`define DCPW_DUTY_PEND2_ADDR 8'h18
`define DCPW_DUTY_ACT2_ADDR  8'h1c
`define DCPW_CH_CTRL2_ADDR   8'h20
`define DCPW_RATE_SEL_ADDR   8'h24
// Reset values
`define DCPW_TB_COUNT_RST    8'h00
`define DCPW_PERIOD_RST      8'hff
`define DCPW_TB_CTRL_RST     8'h00
`define DCPW_CH_CTRL_RST     8'h00
`define DCPW_DUTY_RST        8'h00
// Field positions
`define DCPW_CH_DUTY_LSB_HI  5
`define DCPW_CH_DUTY_LSB_LO  4
`define DCPW_CH_MODE_HI      3
`define DCPW_CH_MODE_LO      0
`define DCPW_TB_ON_BIT       2
`define DCPW_TB_PRE_HI       1
`define DCPW_TB_PRE_LO       0
`define DCPW_TB_POST_HI      6
`define DCPW_TB_POST_LO      3
// Timing: instruction cycle is four oscillator periods
`define DCPW_OSC_PER_CYCLE   4
// Rate select presets: limit for 9.75 kHz and 19.53 kHz at prescale 4
`define DCPW_PERIOD_SLOW     8'hff
`define DCPW_PERIOD_FAST     8'h7f
`define DCPW_PRE_FOR_RATE    2'b01
`endif

// File: shared/dcpw_pkg.sv
package dcpw_pkg;
  typedef enum logic [1:0] {
    DCPW_PRE_1  = 2'b00,
    DCPW_PRE_4  = 2'b01,
    DCPW_PRE_16 = 2'b10
  } dcpw_pre_t;
  typedef enum logic [3:0] {
    DCPW_MODE_OFF = 4'b0000,
    DCPW_MODE_PWM = 4'b1100
  } dcpw_mode_t;
endpackage : dcpw_pkg

// File: design/dcpw_channel.sv
`include "dcpw_map.svh"
module dcpw_channel
  import dcpw_pkg::*;
#(
  parameter int DW = 10
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          enable,
  input  wire logic          periodStart,
  input  wire logic          tick,
  input  wire logic [DW-1:0] timeBase,
  input  wire logic [DW-1:0] dutyPending,
  output logic      [DW-1:0] dutyActive,
  output logic               pwmOut
);
  logic [DW-1:0] dutyActive_r;
  logic          pwmOut_r;
  wire           zeroDuty  = (dutyPending == '0);
  // Look one step ahead: the registered pin drops as the count hits duty
  wire [DW-1:0]  timeNext  = timeBase + DW'(1);
  // (RL10) 10-bit duty match
  wire           dutyMatch = tick && (timeNext == dutyActive_r);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dutyActive_r <= '0;
      pwmOut_r     <= 1'b0;
    end else if (!enable) begin
      pwmOut_r <= 1'b0;
    end else if (periodStart) begin
      // (RL5) latch pending duty
      dutyActive_r <= dutyPending;
      // (RL4) set unless zero duty
      pwmOut_r     <= !zeroDuty;
    end else if (dutyMatch) begin
      // (RL11) no match means stays high
      pwmOut_r <= 1'b0;
    end
  end

  assign dutyActive = dutyActive_r;
  assign pwmOut     = pwmOut_r;
endmodule : dcpw_channel

// File: design/dcpw_top.sv
// Functional notes
// (RL1) Period is (limit+1) x4 osc x prescale
// (RL2) Rate select gives 9.75 or 19.53 kHz
// (RL3) Counter clears after matching the limit
// (RL4) Output set at period start unless zero
// (RL5) Pending duty copied to active at start
// (RL6) Postscaler never affects the period
// (RL7) Duty is 8 high bits plus 2 low
// (RL8) Active duty double-buffers pending writes
// (RL9) 10-bit timebase from counter plus two bits
// (RL10) Output cleared on 10-bit duty match
// (RL11) Duty beyond period keeps output high
// (RL12) Resolution limited by osc over pwm rate
// (RL13) Software keeps reserved bits unchanged
// (RL14) Two identical channels share one timebase
// (RL15) Only motor control owns these registers
// (RL16) Counter steps once per prescaled cycle
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`include "dcpw_map.svh"
module dcpw_top
  import dcpw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             modulator_output_one,
  output logic             modulator_output_two,
  output logic             postscaleEvent
);
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  // Registers
  logic [7:0] timebase_counter_r;
  logic [7:0] period_limit_r;
  logic [6:0] timebase_control_r;
  logic [7:0] duty_pending_one_r;
  logic [7:0] duty_pending_two_r;
  logic [5:0] channel_control_one_r;
  logic [5:0] channel_control_two_r;
  logic       rate_select_r;
  logic [1:0] quarter_r;
  logic [3:0] preCount_r;
  logic [3:0] postCount_r;
  logic       postscaleEvent_r;

  // Bus state
  logic       awHave_r, wHave_r, bvalid_r, rvalid_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // ---------------- Timebase ----------------
  wire        tbOn      = timebase_control_r[`DCPW_TB_ON_BIT];
  wire [1:0]  preSel    =
    timebase_control_r[`DCPW_TB_PRE_HI:`DCPW_TB_PRE_LO];
  wire [3:0]  postSel   =
    timebase_control_r[`DCPW_TB_POST_HI:`DCPW_TB_POST_LO];
  // Quarter counter models the four oscillator phases per cycle
  wire        cycleEnd  = (quarter_r == 2'(`DCPW_OSC_PER_CYCLE - 1));
  wire [3:0]  preLimit  = (preSel == DCPW_PRE_1) ? 4'h0 :
                          (preSel == DCPW_PRE_4) ? 4'h3 : 4'hf;
  // (RL16) one step per prescaled cycle
  wire        tbStep    = tbOn && cycleEnd && (preCount_r == preLimit);
  // (RL3) clear after matching limit
  wire        atLimit   = (timebase_counter_r == period_limit_r);
  wire        periodStart = tbStep && atLimit;
  // (RL9) low bits from quarter clock or prescaler
  wire [1:0]  lowBits   = (preSel == DCPW_PRE_1) ? quarter_r :
                          preCount_r[1:0];
  // High prescale takes upper prescaler bits for an even stride
  wire [1:0]  lowBitsX  = preSel[1] ? preCount_r[3:2] :
                          lowBits;
  // (RL12) resolution set by limit and prescale
  wire [9:0]  timeBase  = {timebase_counter_r, lowBitsX};
  wire        fineTick  = tbOn && (preSel == DCPW_PRE_1 ||
                          (preSel == DCPW_PRE_4 ? cycleEnd :
                           cycleEnd && preCount_r[1:0] == 2'b11));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) quarter_r <= 2'b00;
    else if (tbOn) quarter_r <= quarter_r + 2'b01;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) preCount_r <= 4'h0;
    else if (tbOn && cycleEnd)
      preCount_r <= (preCount_r == preLimit) ? 4'h0 : preCount_r + 4'h1;
  end

  // (RL1) period from limit and prescale
  wire [7:0] tbNext = atLimit ? 8'h00 : timebase_counter_r + 8'h01;

  // (RL6) postscaler counts periods only, output separate
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      postCount_r      <= 4'h0;
      postscaleEvent_r <= 1'b0;
    end else begin
      postscaleEvent_r <= periodStart && (postCount_r == postSel);
      if (periodStart)
        postCount_r <= (postCount_r == postSel) ? 4'h0 : postCount_r + 4'h1;
    end
  end

  // ---------------- Channels ----------------
  // (RL7) duty assembled from 8 high and 2 low
  wire [9:0] pendOne = {duty_pending_one_r,
    channel_control_one_r[`DCPW_CH_DUTY_LSB_HI:`DCPW_CH_DUTY_LSB_LO]};
  wire [9:0] pendTwo = {duty_pending_two_r,
    channel_control_two_r[`DCPW_CH_DUTY_LSB_HI:`DCPW_CH_DUTY_LSB_LO]};
  wire enOne = channel_control_one_r[`DCPW_CH_MODE_HI:`DCPW_CH_MODE_LO]
               == DCPW_MODE_PWM;
  wire enTwo = channel_control_two_r[`DCPW_CH_MODE_HI:`DCPW_CH_MODE_LO]
               == DCPW_MODE_PWM;
  wire [9:0] actOne, actTwo;

  // (RL14) two identical channels
  // (RL8) active duty double buffer
  dcpw_channel #(.DW(10)) u_chOne (
    .clk(clk), .rstn(rstn), .enable(enOne), .periodStart(periodStart),
    .tick(fineTick), .timeBase(timeBase), .dutyPending(pendOne),
    .dutyActive(actOne), .pwmOut(modulator_output_one));
  dcpw_channel #(.DW(10)) u_chTwo (
    .clk(clk), .rstn(rstn), .enable(enTwo), .periodStart(periodStart),
    .tick(fineTick), .timeBase(timeBase), .dutyPending(pendTwo),
    .dutyActive(actTwo), .pwmOut(modulator_output_two));

  // ---------------- AXI4-Lite write ----------------
  wire doWrite = awHave_r && wHave_r && !bvalid_r;
  wire wLane0  = wStrb_r[0];
  wire wTb     = doWrite && wLane0 && awAddr_r == `DCPW_TB_COUNT_ADDR;
  wire wPer    = doWrite && wLane0 && awAddr_r == `DCPW_PERIOD_ADDR;
  wire wTbc    = doWrite && wLane0 && awAddr_r == `DCPW_TB_CTRL_ADDR;
  wire wDp1    = doWrite && wLane0 && awAddr_r == `DCPW_DUTY_PEND1_ADDR;
  wire wCc1    = doWrite && wLane0 && awAddr_r == `DCPW_CH_CTRL1_ADDR;
  wire wDp2    = doWrite && wLane0 && awAddr_r == `DCPW_DUTY_PEND2_ADDR;
  wire wCc2    = doWrite && wLane0 && awAddr_r == `DCPW_CH_CTRL2_ADDR;
  wire wRate   = doWrite && wLane0 && awAddr_r == `DCPW_RATE_SEL_ADDR;
  wire wMapped = awAddr_r == `DCPW_TB_COUNT_ADDR ||
                 awAddr_r == `DCPW_PERIOD_ADDR ||
                 awAddr_r == `DCPW_TB_CTRL_ADDR ||
                 awAddr_r == `DCPW_DUTY_PEND1_ADDR ||
                 awAddr_r == `DCPW_DUTY_ACT1_ADDR ||
                 awAddr_r == `DCPW_CH_CTRL1_ADDR ||
                 awAddr_r == `DCPW_DUTY_PEND2_ADDR ||
                 awAddr_r == `DCPW_DUTY_ACT2_ADDR ||
                 awAddr_r == `DCPW_CH_CTRL2_ADDR ||
                 awAddr_r == `DCPW_RATE_SEL_ADDR;
  wire [7:0] wByte = wData_r[7:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHave_r <= 1'b0;
      wHave_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OK;
    end else begin
      if (s_axi_awvalid && !awHave_r) begin
        awHave_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !wHave_r) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_r <= 1'b0;
        wHave_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wMapped ? RESP_OK : RESP_ERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Register file; rate select preloads the period and prescale
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timebase_counter_r    <= `DCPW_TB_COUNT_RST;
      period_limit_r        <= `DCPW_PERIOD_RST;
      timebase_control_r    <= 7'(`DCPW_TB_CTRL_RST);
      duty_pending_one_r    <= `DCPW_DUTY_RST;
      duty_pending_two_r    <= `DCPW_DUTY_RST;
      channel_control_one_r <= 6'(`DCPW_CH_CTRL_RST);
      channel_control_two_r <= 6'(`DCPW_CH_CTRL_RST);
      rate_select_r         <= 1'b0;
    end else begin
      // Software write wins over the counter step
      if (wTb) timebase_counter_r <= wByte;
      else if (tbStep) timebase_counter_r <= tbNext;
      if (wPer) period_limit_r <= wByte;
      if (wTbc) timebase_control_r <= wByte[6:0];
      if (wDp1) duty_pending_one_r <= wByte;
      if (wDp2) duty_pending_two_r <= wByte;
      if (wCc1) channel_control_one_r <= wByte[5:0];
      if (wCc2) channel_control_two_r <= wByte[5:0];
      // (RL2) 9.75 kHz or 19.53 kHz preset
      if (wRate) begin
        rate_select_r  <= wByte[0];
        period_limit_r <= wByte[0] ? `DCPW_PERIOD_FAST : `DCPW_PERIOD_SLOW;
        timebase_control_r[`DCPW_TB_PRE_HI:`DCPW_TB_PRE_LO] <=
          `DCPW_PRE_FOR_RATE;
      end
    end
  end

  // ---------------- AXI4-Lite read ----------------
  wire [7:0] rAddr = {s_axi_araddr[7:2], 2'b00};
  logic [31:0] rMux;
  logic        rOk;
  always_comb begin
    rOk  = 1'b1;
    case (rAddr)
      `DCPW_TB_COUNT_ADDR:   rMux = {24'h0, timebase_counter_r};
      `DCPW_PERIOD_ADDR:     rMux = {24'h0, period_limit_r};
      `DCPW_TB_CTRL_ADDR:    rMux = {25'h0, timebase_control_r};
      `DCPW_DUTY_PEND1_ADDR: rMux = {24'h0, duty_pending_one_r};
      `DCPW_DUTY_ACT1_ADDR:  rMux = {24'h0, actOne[9:2]};
      `DCPW_CH_CTRL1_ADDR:   rMux = {26'h0, channel_control_one_r};
      `DCPW_DUTY_PEND2_ADDR: rMux = {24'h0, duty_pending_two_r};
      `DCPW_DUTY_ACT2_ADDR:  rMux = {24'h0, actTwo[9:2]};
      `DCPW_CH_CTRL2_ADDR:   rMux = {26'h0, channel_control_two_r};
      `DCPW_RATE_SEL_ADDR:   rMux = {31'h0, rate_select_r};
      default: begin
        rMux = 32'h0000_0000;
        rOk  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OK;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rMux;
      rresp_r  <= rOk ? RESP_OK : RESP_ERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready  = !awHave_r;
  assign s_axi_wready   = !wHave_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = !rvalid_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rdata    = rdata_r;
  assign s_axi_rresp    = rresp_r;
  assign postscaleEvent = postscaleEvent_r;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_counter_wrap: assert property ( // RL3
    periodStart && !wTb |=> timebase_counter_r == 8'h00)
    else $error("timebase did not clear at limit");
  a_active_load: assert property ( // RL5
    periodStart && enOne |=> actOne == $past(pendOne))
    else $error("duty not latched at period start");
  a_output_set: assert property ( // RL4
    periodStart && enOne && pendOne != 10'h0 |=> modulator_output_one)
    else $error("output not set at period start");
  a_zero_duty: assert property ( // RL4
    periodStart && enOne && pendOne == 10'h0 |=> !modulator_output_one)
    else $error("zero duty output went high");
  a_match_clear: assert property ( // RL10
    enOne && !periodStart && fineTick && 10'(timeBase + 10'h1) == actOne
      |=> !modulator_output_one)
    else $error("output not cleared on match");
  a_buffer_hold: assert property ( // RL8
    !periodStart |=> actTwo == $past(actTwo))
    else $error("active duty changed mid period");
  a_step_rate: assert property ( // RL16
    tbStep && preSel == DCPW_PRE_1 |=> !tbStep [*3])
    else $error("timebase stepped faster than a cycle");
  a_chan_equal: assert property ( // RL14
    enOne && enTwo && pendOne == pendTwo && periodStart
      |=> modulator_output_one == modulator_output_two)
    else $error("channels differ on equal duty");
  a_post_period: assert property ( // RL6
    wPer |=> period_limit_r == $past(wByte))
    else $error("period limit write lost");

  c_period: cover property (periodStart ##1 modulator_output_one);
  c_match: cover property (modulator_output_one ##1 !modulator_output_one);
  c_rate: cover property (wRate && wByte[0]);
  c_rd: cover property (rvalid_r && s_axi_rready);
endmodule : dcpw_top

// File: sim/dcpw_stage_model.sv
// Power stage load: measures pulse and period lengths on one pin
module dcpw_stage_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pwmIn,
  output int        highLen,
  output int        periodLen,
  output int        riseCount
);
  timeunit 1ns;
  timeprecision 1ns;
  int   nowCnt;
  int   riseAt;
  logic prevIn;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nowCnt    <= 0;
      riseAt    <= 0;
      prevIn    <= 1'b0;
      highLen   <= 0;
      periodLen <= 0;
      riseCount <= 0;
    end else begin
      nowCnt <= nowCnt + 1;
      prevIn <= pwmIn;
      // Period is rise to rise and high time rise to fall, so a lone first pulse reads oddly
      if (pwmIn && !prevIn) begin
        periodLen <= nowCnt - riseAt;
        riseAt    <= nowCnt;
        riseCount <= riseCount + 1;
      end
      if (!pwmIn && prevIn) begin
        highLen <= nowCnt - riseAt;
      end
    end
  end
endmodule : dcpw_stage_model

// File: sim/tb_top.sv
`include "dcpw_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, awValid, wValid, bReady, arValid, rReady;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rd;
  logic [3:0] wStrb;
  logic awRdy, wRdy, bValid, arRdy, rValid, out1, out2, postEv;
  logic [1:0] bResp, rResp, rsp;
  logic [31:0] rData;
  int hi1, per1, rise1, hi2, per2, rise2, err_total, total_checks, k;

  dcpw_top i_dcpw_top (.clk(clk), .rstn(rstn), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awRdy), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wRdy),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arRdy),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .modulator_output_one(out1),
    .modulator_output_two(out2), .postscaleEvent(postEv));
  dcpw_stage_model i_stage1 (.clk(clk), .rstn(rstn), .pwmIn(out1),
    .highLen(hi1), .periodLen(per1), .riseCount(rise1));
  dcpw_stage_model i_stage2 (.clk(clk), .rstn(rstn), .pwmIn(out2),
    .highLen(hi2), .periodLen(per2), .riseCount(rise2));

  always #2 clk = ~clk;

  task automatic test_done;
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: data %h expected %h", $time, got, exp);
    end
  endtask : chkData

  task automatic chkCount(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      err_total++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chkCount

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awAddr <= a; wData <= d; awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awValid && awRdy) awValid <= 1'b0;
      if (wValid && wRdy) wValid <= 1'b0;
    end while (!(bValid && bReady) && n < 200);
    if (n >= 200) chkCount(n, 0);
    rsp = bResp;
    bReady <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a);
    int n;
    @(posedge clk);
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arValid && arRdy) arValid <= 1'b0;
    end while (!(rValid && rReady) && n < 200);
    if (n >= 200) chkCount(n, 0);
    rd = rData;
    rsp = rResp;
    rReady <= 1'b0;
  endtask : axiRead

  task automatic readChk(input logic [7:0] a, input logic [7:0] exp);
    axiRead(a);
    chkData(rd, {24'h0, exp});
    chkData({30'h0, rsp}, 32'h0);
  endtask : readChk

  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask : waitClk

  initial begin
    #150000;
    err_total++;
    test_done();
  end

  initial begin
    clk = 0; rstn = 0; awValid = 0; wValid = 0; bReady = 0; arValid = 0;
    rReady = 0; awAddr = 0; arAddr = 0; wData = 0; wStrb = 4'hf;
    err_total = 0; total_checks = 0;
    waitClk(3);
    rstn <= 1'b1;
    readChk(`DCPW_TB_COUNT_ADDR, `DCPW_TB_COUNT_RST);
    readChk(`DCPW_PERIOD_ADDR, `DCPW_PERIOD_RST);
    readChk(`DCPW_TB_CTRL_ADDR, `DCPW_TB_CTRL_RST);
    readChk(`DCPW_CH_CTRL1_ADDR, `DCPW_CH_CTRL_RST);
    readChk(`DCPW_CH_CTRL2_ADDR, `DCPW_CH_CTRL_RST);
    readChk(`DCPW_RATE_SEL_ADDR, 8'h00);
    // Unmapped place answers with a slave error
    axiWrite(8'h3c, 32'h5a);
    chkData({30'h0, rsp}, 32'h2);
    axiRead(8'h3c);
    chkData({rd[29:0], rsp}, 32'h2);
    // Limit 9, prescale 1: 40 clocks a period; duty 13 and 22
    axiWrite(`DCPW_PERIOD_ADDR, 32'h09);
    axiWrite(`DCPW_DUTY_PEND1_ADDR, 32'h03);
    axiWrite(`DCPW_CH_CTRL1_ADDR, 32'h1c);
    axiWrite(`DCPW_DUTY_PEND2_ADDR, 32'h05);
    axiWrite(`DCPW_CH_CTRL2_ADDR, 32'h2c);
    axiWrite(`DCPW_TB_CTRL_ADDR, 32'h04);
    waitClk(200);
    chkCount(per1, 40);
    chkCount(hi1, 13);
    chkCount(per2, 40);
    chkCount(hi2, 22);
    readChk(`DCPW_DUTY_ACT1_ADDR, 8'h03);
    // Zero duty: no rising edge at all
    axiWrite(`DCPW_DUTY_PEND1_ADDR, 32'h00);
    axiWrite(`DCPW_CH_CTRL1_ADDR, 32'h0c);
    waitClk(100);
    k = rise1;
    waitClk(120);
    chkCount(rise1 - k, 0);
    chkData({31'h0, out1}, 32'h0);
    // Duty past the period: held high throughout
    axiWrite(`DCPW_DUTY_PEND2_ADDR, 32'hff);
    axiWrite(`DCPW_CH_CTRL2_ADDR, 32'h3c);
    waitClk(100);
    k = 0;
    repeat (80) begin
      @(posedge clk);
      if (out2 === 1'b1) k++;
    end
    chkCount(k, 80);
    // New duty lands only through the active copy
    axiWrite(`DCPW_DUTY_PEND1_ADDR, 32'h07);
    waitClk(120);
    readChk(`DCPW_DUTY_ACT1_ADDR, 8'h07);
    chkCount(hi1, 28);
    axiWrite(`DCPW_DUTY_ACT1_ADDR, 32'h55);
    readChk(`DCPW_DUTY_ACT1_ADDR, 8'h07);
    // Postscale 3: event every 4 periods, period unchanged
    axiWrite(`DCPW_TB_CTRL_ADDR, 32'h1c);
    k = 0;
    while (postEv !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (postEv !== 1'b1 && k < 500);
    chkCount(k, 160);
    waitClk(100);
    chkCount(per1, 40);
    // Prescale 16: 640 clocks a period, duty 28 spans 448
    axiWrite(`DCPW_TB_CTRL_ADDR, 32'h06);
    waitClk(1500);
    chkCount(per1, 640);
    chkCount(hi1, 448);
    // Rate presets with prescale 4
    axiWrite(`DCPW_RATE_SEL_ADDR, 32'h01);
    readChk(`DCPW_PERIOD_ADDR, `DCPW_PERIOD_FAST);
    axiRead(`DCPW_TB_CTRL_ADDR);
    chkData({30'h0, rd[1:0]}, 32'h1);
    axiWrite(`DCPW_TB_CTRL_ADDR, 32'h05);
    waitClk(5000);
    chkCount(per1, 2048);
    chkCount(hi1, 112);
    axiWrite(`DCPW_RATE_SEL_ADDR, 32'h00);
    readChk(`DCPW_PERIOD_ADDR, `DCPW_PERIOD_SLOW);
    axiWrite(`DCPW_TB_CTRL_ADDR, 32'h05);
    waitClk(9000);
    chkCount(per1, 4096);
    test_done();
  end
endmodule : tb_top
